// *** rtl/eprom_programmer.sv ***
// host-side controller that sequences supplies and pins of a 16-bit eprom
// assumes supply switches follow the enables; data pins are three signals each
//
// Contract
// - with chip and output enable low, the memory drives the addressed word.
// - core at 5 V for reading, raised to 6.2 V while programming and verifying.
// - identifier read puts identifier line at high voltage, kind bit selects code.
// - core supply rises no later and falls no earlier than programming supply.
// - never switch programming supply while chip enable and strobe are low.
// - program strobe is high before programming supply is applied.
`timescale 1ns/1ps
module eprom_programmer
	import eprom_prog_pkg::*;
(
	// system
	input  wire logic              clock,
	input  wire logic              rst_n,
	// user commands
	input  wire logic              cmd_valid,
	input  wire logic [1:0]        cmd_op,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_data,
	output logic                   cmd_ready,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	output logic                   rsp_match,
	// memory pins
	output logic                   chip_enable_n,
	output logic                   output_enable_n,
	output logic                   program_strobe_n,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic                   identifier_select_hv,
	output logic [DATA_W-1:0]      mem_data_out,
	output logic                   mem_data_oe,
	input  wire logic [DATA_W-1:0] mem_data_in,
	// supply switches
	output logic                   vcc_on,
	output logic                   vcc_high,
	output logic                   vpp_high
);
	state_type         st_r, st_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [1:0]        op_r, op_nxt;
	logic              ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, pg_n_r, pg_n_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] dout_r, dout_nxt;
	logic              doe_r, doe_nxt, hv_r, hv_nxt;
	logic              vcc_r, vcc_nxt, vcch_r, vcch_nxt, vpp_r, vpp_nxt;
	logic              rdy_r, rdy_nxt, rv_r, rv_nxt, rm_r, rm_nxt;
	logic [DATA_W-1:0] rd_r, rd_nxt;
	logic              cnt_done;

	assign cnt_done = (cnt_r == CNT_ZERO);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_done ? CNT_ZERO : cnt_r - CNT_ONE;
		op_nxt = op_r;
		ce_n_nxt = ce_n_r;
		oe_n_nxt = oe_n_r;
		pg_n_nxt = pg_n_r;
		addr_nxt = addr_r;
		dout_nxt = dout_r;
		doe_nxt = doe_r;
		hv_nxt = hv_r;
		vcc_nxt = vcc_r;
		vcch_nxt = vcch_r;
		vpp_nxt = vpp_r;
		rdy_nxt = 1'b0;
		rv_nxt = 1'b0;
		rm_nxt = rm_r;
		rd_nxt = rd_r;
		case (st_r)
			ST_OFF: begin
				// strobe held high before any programming supply
				pg_n_nxt = 1'b1;
				ce_n_nxt = 1'b1;
				oe_n_nxt = 1'b1;
				vcc_nxt = 1'b1;
				cnt_nxt = CNT_W'(C_VS);
				st_nxt = ST_VCC_UP;
			end
			ST_VCC_UP: begin
				if (cnt_done) begin
					rdy_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				rdy_nxt = 1'b1;
				if (cmd_valid) begin
					rdy_nxt = 1'b0;
					op_nxt = cmd_op;
					addr_nxt = cmd_addr;
					dout_nxt = cmd_data;
					case (cmd_op)
						CMD_PROG: begin
							// core raised in the same cycle as the high programming supply
							vcch_nxt = 1'b1;
							vpp_nxt = 1'b1;
							doe_nxt = 1'b1;
							hv_nxt = 1'b0;
							cnt_nxt = CNT_W'(C_AS);
							st_nxt = ST_SETUP;
						end
						CMD_ID: begin
							// other address lines low, kind bit from the command
							addr_nxt = ADDR_ZERO;
							addr_nxt[ID_KIND_BIT] = cmd_addr[ID_KIND_BIT];
							addr_nxt[ID_LINE_BIT] = 1'b0;
							hv_nxt = 1'b1;
							cnt_nxt = CNT_W'(C_AS);
							st_nxt = ST_SETUP;
						end
						CMD_PWR_DOWN: begin
							// programming supply off before core
							vpp_nxt = 1'b0;
							cnt_nxt = CNT_W'(C_VS);
							st_nxt = ST_VPP_DN;
						end
						default: begin
							hv_nxt = 1'b0;
							cnt_nxt = CNT_W'(C_AS);
							st_nxt = ST_SETUP;
						end
					endcase
				end
			end
			ST_SETUP: begin
				// programming supply is settled before the strobe falls
				if (cnt_done) begin
					if (op_r == CMD_PROG) begin
						ce_n_nxt = 1'b0;
						oe_n_nxt = 1'b1;
						pg_n_nxt = 1'b0;
						cnt_nxt = CNT_W'(C_PW);
						st_nxt = ST_PULSE;
					end else begin
						ce_n_nxt = 1'b0;
						oe_n_nxt = 1'b0;
						cnt_nxt = CNT_W'(C_OE);
						st_nxt = ST_READ;
					end
				end
			end
			ST_PULSE: begin
				// supplies untouched while chip enable and strobe are low
				if (cnt_done) begin
					pg_n_nxt = 1'b1;
					cnt_nxt = CNT_W'(C_DH);
					st_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cnt_done) begin
					doe_nxt = 1'b0;
					oe_n_nxt = 1'b0;
					cnt_nxt = CNT_W'(C_OE);
					st_nxt = ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				if (cnt_done) begin
					rd_nxt = mem_data_in;
					rm_nxt = (mem_data_in == dout_r);
					rv_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					ce_n_nxt = 1'b1;
					cnt_nxt = CNT_W'(C_DF);
					st_nxt = ST_FLOAT;
				end
			end
			ST_READ: begin
				if (cnt_done) begin
					rd_nxt = mem_data_in;
					rm_nxt = 1'b1;
					rv_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					ce_n_nxt = 1'b1;
					cnt_nxt = CNT_W'(C_DF);
					st_nxt = ST_FLOAT;
				end
			end
			ST_FLOAT: begin
				// drop supplies only once the cycle is over and strobe high
				if (cnt_done) begin
					hv_nxt = 1'b0;
					vpp_nxt = 1'b0;
					vcch_nxt = vpp_r;
					if (!vpp_r) begin
						rdy_nxt = 1'b1;
						st_nxt = ST_IDLE;
					end else begin
						cnt_nxt = CNT_W'(C_VS);
					end
				end
			end
			ST_VPP_DN: begin
				if (cnt_done) begin
					vcch_nxt = 1'b0;
					vcc_nxt = 1'b0;
					st_nxt = ST_VPP_DN;
				end
			end
			default: st_nxt = ST_OFF;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= ST_OFF;
			cnt_r <= CNT_ZERO;
			op_r <= CMD_READ;
			ce_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			pg_n_r <= 1'b1;
			addr_r <= ADDR_ZERO;
			dout_r <= DATA_ZERO;
			doe_r <= 1'b0;
			hv_r <= 1'b0;
			vcc_r <= 1'b0;
			vcch_r <= 1'b0;
			vpp_r <= 1'b0;
			rdy_r <= 1'b0;
			rv_r <= 1'b0;
			rm_r <= 1'b0;
			rd_r <= DATA_ZERO;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			op_r <= op_nxt;
			ce_n_r <= ce_n_nxt;
			oe_n_r <= oe_n_nxt;
			pg_n_r <= pg_n_nxt;
			addr_r <= addr_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
			hv_r <= hv_nxt;
			vcc_r <= vcc_nxt;
			vcch_r <= vcch_nxt;
			vpp_r <= vpp_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
			rm_r <= rm_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign cmd_ready = rdy_r;
	assign rsp_valid = rv_r;
	assign rsp_data = rd_r;
	assign rsp_match = rm_r;
	assign chip_enable_n = ce_n_r;
	assign output_enable_n = oe_n_r;
	assign program_strobe_n = pg_n_r;
	assign mem_addr = addr_r;
	assign identifier_select_hv = hv_r;
	assign mem_data_out = dout_r;
	assign mem_data_oe = doe_r;
	assign vcc_on = vcc_r;
	assign vcc_high = vcch_r;
	assign vpp_high = vpp_r;
endmodule : eprom_programmer

// *** common/eprom_prog_pkg.sv ***
// constants for the host-side programmer of a 16-bit-wide eprom
// assumes a 250 MHz system clock; supply switches are external, driven by enables
package eprom_prog_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	localparam int CLK_MHZ = 250;
	// times in ns, as printed
	localparam int T_AS_NS = 2000;
	localparam int T_DS_NS = 2000;
	localparam int T_DH_NS = 2000;
	localparam int T_VS_NS = 2000;
	localparam int T_OE_NS = 55;
	localparam int T_DF_NS = 55;
	localparam int T_PW_NS = 100000;
	// every time rounds up to whole cycles
	localparam int C_AS = (T_AS_NS * CLK_MHZ + 999) / 1000;
	localparam int C_DS = (T_DS_NS * CLK_MHZ + 999) / 1000;
	localparam int C_DH = (T_DH_NS * CLK_MHZ + 999) / 1000;
	localparam int C_VS = (T_VS_NS * CLK_MHZ + 999) / 1000;
	localparam int C_OE = (T_OE_NS * CLK_MHZ + 999) / 1000;
	localparam int C_DF = (T_DF_NS * CLK_MHZ + 999) / 1000;
	localparam int C_PW = (T_PW_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam int ID_LINE_BIT = 9;
	localparam int ID_KIND_BIT = 0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0_0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_PROG = 2'h1;
	localparam logic [1:0] CMD_ID = 2'h2;
	localparam logic [1:0] CMD_PWR_DOWN = 2'h3;
	typedef enum logic [3:0] {
		ST_OFF = 4'h0,
		ST_VCC_UP = 4'h1,
		ST_IDLE = 4'h3,
		ST_SETUP = 4'h2,
		ST_PULSE = 4'h6,
		ST_HOLD = 4'h7,
		ST_VERIFY = 4'h5,
		ST_FLOAT = 4'h4,
		ST_READ = 4'hc,
		ST_VPP_DN = 4'hd
	} state_type;
endpackage : eprom_prog_pkg

// *** sim/eprom_programmer_sva.sv ***
// pin and supply assertions for the eprom programmer
// assumes it is bound onto eprom_programmer, one clock domain
`timescale 1ns/1ps
module eprom_programmer_sva
	import eprom_prog_pkg::*;
(
	// system
	input wire logic              clock,
	input wire logic              rst_n,
	// memory pins
	input wire logic              chip_enable_n,
	input wire logic              output_enable_n,
	input wire logic              program_strobe_n,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              identifier_select_hv,
	input wire logic              mem_data_oe,
	// supply switches
	input wire logic              vcc_on,
	input wire logic              vcc_high,
	input wire logic              vpp_high
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_core_before_vpp: assert property (vpp_high |-> vcc_on) else $error("vpp up without core");
	a_vpp_steady_pulse: assert property (!chip_enable_n && !program_strobe_n |-> $stable(vpp_high))
		else $error("vpp switched in pulse");
	a_strobe_before_vpp: assert property ($rose(vpp_high) |-> program_strobe_n) else $error("strobe low at vpp");
	a_pulse_supplies: assert property (!program_strobe_n |-> vcc_high && vpp_high) else $error("pulse at 5 V");
	a_write_mode: assert property (!program_strobe_n |-> output_enable_n && mem_data_oe)
		else $error("write mode pins wrong");
	a_no_contention: assert property (!output_enable_n |-> !mem_data_oe) else $error("data bus contention");
	a_oe_with_ce: assert property (!output_enable_n |-> !chip_enable_n) else $error("output on without chip");
	a_id_addr_low: assert property (identifier_select_hv |-> mem_addr[ADDR_W-1:1] == '0 && !vcc_high)
		else $error("identifier address or core wrong");
	c_pulse: cover property ($fell(program_strobe_n));
	c_id_read: cover property (identifier_select_hv && !output_enable_n);
	c_down: cover property ($fell(vcc_on));
endmodule : eprom_programmer_sva

// *** sim/eprom_model.sv ***
// pin-level model of a 16-bit eprom, erased cells read ffff
// assumes clock only to make released data lines wander
`timescale 1ns/1ps
module eprom_model
	import eprom_prog_pkg::*;
#(
	parameter logic [DATA_W-1:0] MAKER_CODE = 16'h0011, // arbitrary
	parameter logic [DATA_W-1:0] PART_CODE  = 16'h0022  // arbitrary
)(
	// pins
	input wire logic              clock,
	input wire logic              chip_enable_n,
	input wire logic              output_enable_n,
	input wire logic              program_strobe_n,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              identifier_select_hv,
	input wire logic [DATA_W-1:0] mem_data_out,
	input wire logic              mem_data_oe,
	input wire logic              vcc_on,
	input wire logic              vcc_high,
	input wire logic              vpp_high,
	output logic [DATA_W-1:0]     mem_data_in
);
	logic [DATA_W-1:0] cells [int];
	logic [DATA_W-1:0] float_r = 16'h5a5a;
	logic [DATA_W-1:0] word;
	always @(posedge clock) float_r <= ~float_r;
	// a pulse only clears bits, as a real cell does
	always @(negedge program_strobe_n)
		if (!chip_enable_n && output_enable_n && vcc_high && vpp_high && mem_data_oe)
			cells[int'(mem_addr)] = (cells.exists(int'(mem_addr)) ? cells[int'(mem_addr)] : 16'hffff) & mem_data_out;
	always @* begin
		word = cells.exists(int'(mem_addr)) ? cells[int'(mem_addr)] : 16'hffff;
		if (identifier_select_hv)
			word = mem_addr[ID_KIND_BIT] ? PART_CODE : MAKER_CODE;
		mem_data_in = (!chip_enable_n && !output_enable_n && vcc_on) ? word : float_r;
	end
endmodule : eprom_model

// *** sim/tb_top.sv ***
// self-checking bench: programmer driving a pin-level eprom model
// assumes nothing outside; the checker is bound at the foot
`timescale 1ns/1ps
module tb_top;
	import eprom_prog_pkg::*;
	localparam logic [DATA_W-1:0] MAKER = 16'h0011; // arbitrary
	localparam logic [DATA_W-1:0] PART  = 16'h0022; // arbitrary
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic              cmd_valid = 1'b0;
	logic [1:0]        cmd_op = CMD_READ;
	logic [ADDR_W-1:0] cmd_addr = ADDR_ZERO;
	logic [DATA_W-1:0] cmd_data = DATA_ZERO;
	logic              cmd_ready, rsp_valid, rsp_match, chip_enable_n, output_enable_n, program_strobe_n;
	logic              identifier_select_hv, mem_data_oe, vcc_on, vcc_high, vpp_high;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] rsp_data, mem_data_out, mem_data_in;
	int                err_count = 0;
	int                tests_run = 0;
	int                cycles = 0;
	always #2 clock = ~clock;
	eprom_programmer i_eprom_programmer (.*);
	eprom_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_eprom_model (.*);
	task automatic check(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// raised at a falling edge that sees ready, or after 1000 falling edges without it, so the next rising edge takes it
	task automatic run(logic [1:0] op, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(negedge clock);
		while (cmd_ready !== 1'b1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		{cmd_valid, cmd_op, cmd_addr, cmd_data} = {1'b1, op, a, d};
		@(negedge clock);
		cmd_valid = 1'b0;
		n = 0;
		if (op != CMD_PWR_DOWN) begin
			do begin
				@(posedge clock);
				#1;
			end while (rsp_valid !== 1'b1 && ++n < 30000);
			check("response", 16'h0001, {15'h0000, rsp_valid});
		end
	endtask : run
	task automatic t_power_up();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < C_VS + 20) begin @(posedge clock); #1; n++; end
		check("ready", 16'h0001, {15'h0000, cmd_ready});
		check("core on", 16'h0001, {15'h0000, vcc_on});
		check("supplies low", 16'h0000, {14'h0000, vcc_high, vpp_high});
	endtask : t_power_up
	task automatic t_program(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		run(CMD_PROG, a, d);
		check("verify word", d, rsp_data);
		check("verify match", 16'h0001, {15'h0000, rsp_match});
	endtask : t_program
	task automatic t_read(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
		run(CMD_READ, a, DATA_ZERO);
		check("read word", exp, rsp_data);
		check("read match", 16'h0001, {15'h0000, rsp_match});
	endtask : t_read
	task automatic t_ident();
		run(CMD_ID, ADDR_ZERO, DATA_ZERO);
		check("maker code", MAKER, rsp_data);
		run(CMD_ID, 17'h0_0001, DATA_ZERO);
		check("part code", PART, rsp_data);
	endtask : t_ident
	// power down is terminal, so it runs last
	task automatic t_power_down();
		run(CMD_PWR_DOWN, ADDR_ZERO, DATA_ZERO);
		repeat (2000) @(posedge clock);
		#1;
		check("supplies off", 16'h0000, {13'h0000, vcc_on, vpp_high, cmd_ready});
	endtask : t_power_down
	task automatic results();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	initial begin
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		t_power_up();
		t_program(17'h1_ffff, 16'ha5a5);
		t_program(17'h0_0000, 16'h5a3c);
		t_read(17'h1_ffff, 16'ha5a5);
		t_read(17'h0_0000, 16'h5a3c);
		t_read(17'h0_0200, 16'hffff);
		t_ident();
		t_power_down();
		results();
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			err_count++;
			results();
		end
	end
endmodule : tb_top
bind eprom_programmer eprom_programmer_sva i_eprom_programmer_sva (.*);
